// >>> rtl/gcsa_pkg.sv
// Package with opcodes, widths and field constants of the compare/subtract ALU.
package gcsa_pkg;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned OPC_W   = 8;
  localparam int unsigned MOD_W   = 7;
  localparam int unsigned REG_W   = 7;
  localparam int unsigned SLOT_W  = 3;
  localparam int unsigned NSLOT   = 5;

  localparam logic [OPC_W-1:0] OPC_SUB    = 8'h0d;
  localparam logic [OPC_W-1:0] OPC_NEQ    = 8'h27;
  localparam logic [OPC_W-1:0] OPC_NEQI   = 8'h03;
  localparam logic [OPC_W-1:0] OPC_NZSEL  = 8'h2f;
  localparam logic [OPC_W-1:0] OPC_ZSEL   = 8'h2e;
  localparam logic [OPC_W-1:0] OPC_SUBI   = 8'h20;

  localparam logic [DATA_W-1:0] ZERO_W    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ONE_W     = 32'h0000_0001;
  localparam int unsigned       GUARD_BIT = 0;
  localparam int unsigned       MOD_MSB   = MOD_W - 1;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h5;
  localparam logic [SLOT_W-1:0] SLOT_NONE = 3'h0;
endpackage

// >>> rtl/gcsa_compare.sv
// Zero test and inequality helper shared by the compare and select paths.
`timescale 1ns/100ps
module gcsa_compare
  import gcsa_pkg::*;
(
  // Operands
  input  wire logic [DATA_W-1:0] a_i,
  input  wire logic [DATA_W-1:0] b_i,
  // Results
  output wire logic              neq_o,
  output wire logic              a_zero_o
);
  assign neq_o    = (a_i != b_i);
  assign a_zero_o = (a_i == ZERO_W);
endmodule // gcsa_compare

// >>> rtl/gcsa_alu.sv
// Guarded compare, zero-select and subtract ALU slice with one-cycle latency.
`timescale 1ns/100ps
module gcsa_alu
  import gcsa_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Issue
  input  wire logic              issue_valid_i,
  input  wire logic [SLOT_W-1:0] issue_slot_i,
  input  wire logic [OPC_W-1:0]  opcode_i,
  input  wire logic [MOD_W-1:0]  modifier_i,
  input  wire logic [REG_W-1:0]  dest_reg_i,
  // Operands
  input  wire logic [DATA_W-1:0] first_source_i,
  input  wire logic [DATA_W-1:0] second_source_i,
  input  wire logic              guard_present_i,
  input  wire logic [DATA_W-1:0] guard_value_i,
  // Write-back
  output logic                   wb_en_o,
  output logic [REG_W-1:0]       wb_reg_o,
  output logic [DATA_W-1:0]      wb_data_o,
  output logic [SLOT_W-1:0]      wb_slot_o,
  output logic                   wb_unknown_op_o
);

  // Opcode match, shared by every decode line below.
  function automatic logic op_is(
    input logic [OPC_W-1:0] code,
    input logic [OPC_W-1:0] want
  );
    op_is = (code == want);
  endfunction

  // Plain modulo subtraction: the borrow out is dropped on purpose, so no
  // overflow is ever flagged and the caller sees the wrapped word.
  function automatic logic [DATA_W-1:0] sub32(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b
  );
    sub32 = a - b;
  endfunction

  // Turns a compare outcome into a full-width result word.
  function automatic logic [DATA_W-1:0] flag_word(
    input logic flag
  );
    flag_word = flag ? ONE_W : ZERO_W;
  endfunction

  // Opcode decode.
  wire logic              dec_neq;
  wire logic              dec_neqi;
  wire logic              dec_nzsel;
  wire logic              dec_zsel;
  wire logic              dec_sub;
  wire logic              dec_subi;
  wire logic              op_known;

  // Operand preparation.
  wire logic [DATA_W-1:0] imm_signed;
  wire logic [DATA_W-1:0] imm_unsigned;
  wire logic [DATA_W-1:0] cmp_b;
  wire logic              src_neq;
  wire logic              src_zero;

  // Per-operation results.
  wire logic [DATA_W-1:0] res_neq;
  wire logic [DATA_W-1:0] res_neqi;
  wire logic [DATA_W-1:0] res_nzsel;
  wire logic [DATA_W-1:0] res_zsel;
  wire logic [DATA_W-1:0] res_sub;
  wire logic [DATA_W-1:0] res_subi;
  wire logic [DATA_W-1:0] result;

  // Write qualification.
  wire logic              guard_ok;
  wire logic              slot_ok;
  wire logic              issue_ok;

  // Next register values.
  wire logic              next_wb_en;
  wire logic [REG_W-1:0]  next_wb_reg;
  wire logic [DATA_W-1:0] next_wb_data;
  wire logic [SLOT_W-1:0] next_wb_slot;
  wire logic              next_wb_unknown;

  assign dec_neq   = op_is(opcode_i, OPC_NEQ);
  assign dec_neqi  = op_is(opcode_i, OPC_NEQI);
  assign dec_nzsel = op_is(opcode_i, OPC_NZSEL);
  assign dec_zsel  = op_is(opcode_i, OPC_ZSEL);
  assign dec_sub   = op_is(opcode_i, OPC_SUB);
  assign dec_subi  = op_is(opcode_i, OPC_SUBI);

  assign op_known = dec_neq  || dec_neqi || dec_nzsel ||
                    dec_zsel || dec_sub  || dec_subi;

  // Sign extension of the modifier for the immediate compare.
  assign imm_signed   = {{(DATA_W-MOD_W){modifier_i[MOD_MSB]}},
                         modifier_i};

  // Zero extension: a seven-bit field cannot hold more than 127, so the
  // supplier's range limit is met by construction.
  assign imm_unsigned = {{(DATA_W-MOD_W){1'b0}}, modifier_i};

  // One comparator serves both compares; only its second input moves.
  assign cmp_b = dec_neqi ? imm_signed : second_source_i;

  gcsa_compare u_cmp (
    .a_i      (first_source_i),
    .b_i      (cmp_b),
    .neq_o    (src_neq),
    .a_zero_o (src_zero)
  );

  assign res_neq   = flag_word(src_neq);

  assign res_neqi  = flag_word(src_neq);

  // A zero first source passes the second source, anything else clears.
  assign res_nzsel = src_zero ? second_source_i : ZERO_W;

  // The mirror image: a zero first source clears.
  assign res_zsel  = src_zero ? ZERO_W : second_source_i;

  // The same adder result serves signed and unsigned operands.
  assign res_sub   = sub32(first_source_i, second_source_i);

  assign res_subi  = sub32(first_source_i, imm_unsigned);

  // Unknown opcodes give a zero word; the write is suppressed anyway.
  assign result = dec_neq   ? res_neq   :
                  dec_neqi  ? res_neqi  :
                  dec_nzsel ? res_nzsel :
                  dec_zsel  ? res_zsel  :
                  dec_sub   ? res_sub   :
                  dec_subi  ? res_subi  :
                              ZERO_W;

  // Missing guard behaves as a true guard.
  assign guard_ok = !guard_present_i || guard_value_i[GUARD_BIT];

  // Any of the five slots may issue; slot zero means no slot.
  assign slot_ok  = (issue_slot_i != SLOT_NONE) &&
                    (issue_slot_i <= SLOT_LAST);

  assign issue_ok = issue_valid_i && slot_ok && op_known;

  assign next_wb_en      = issue_ok && guard_ok;
  assign next_wb_reg     = dest_reg_i;
  assign next_wb_data    = result;
  assign next_wb_slot    = issue_slot_i;
  assign next_wb_unknown = issue_valid_i && !op_known;

  // Each output has its own short register so every operation retires
  // exactly one cycle after issue.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_en_o <= 1'b0;
    end else begin
      wb_en_o <= next_wb_en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_reg_o <= '0;
    end else begin
      wb_reg_o <= next_wb_reg;
    end
  end

  // The data word is loaded on every cycle; a guarded-off write still shows
  // its result here, and only the enable keeps the register file intact.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_data_o <= ZERO_W;
    end else begin
      wb_data_o <= next_wb_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_slot_o <= SLOT_NONE;
    end else begin
      wb_slot_o <= next_wb_slot;
    end
  end

  // Flags a valid issue this slice cannot execute, for the issue logic.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_unknown_op_o <= 1'b0;
    end else begin
      wb_unknown_op_o <= next_wb_unknown;
    end
  end

endmodule // gcsa_alu

// >>> dv/gcsa_chk.sv
// Checker of write-back results against the operation issued a cycle before.
`timescale 1ns/100ps
module gcsa_chk
  import gcsa_pkg::*;
(
  input wire logic              clk_i, rst_i, issue_valid_i, guard_present_i,
  input wire logic              wb_en_o, wb_unknown_op_o,
  input wire logic [SLOT_W-1:0] issue_slot_i,
  input wire logic [OPC_W-1:0]  opcode_i,
  input wire logic [MOD_W-1:0]  modifier_i,
  input wire logic [DATA_W-1:0] first_source_i, second_source_i,
  input wire logic [DATA_W-1:0] guard_value_i, wb_data_o
);
  logic [DATA_W-1:0] a, b, m;
  wire kn = opcode_i inside {OPC_SUB, OPC_NEQ, OPC_NEQI, OPC_NZSEL, OPC_ZSEL,
                             OPC_SUBI};
  wire ok = issue_valid_i && issue_slot_i inside {[1:5]} &&
            (!guard_present_i || guard_value_i[GUARD_BIT]);
  always_ff @(posedge clk_i) begin
    a <= first_source_i;
    b <= second_source_i;
    m <= {{25{modifier_i[6]}}, modifier_i};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_neq; ok && opcode_i == OPC_NEQ |=> wb_data_o == 32'(a != b);
  endproperty
  property p_nqi; ok && opcode_i == OPC_NEQI |=> wb_data_o == 32'(a != m);
  endproperty
  property p_nz; ok && opcode_i == OPC_NZSEL |=> wb_data_o == (a ? 0 : b);
  endproperty
  property p_z; ok && opcode_i == OPC_ZSEL |=> wb_data_o == (a ? b : 0);
  endproperty
  property p_sub; ok && opcode_i == OPC_SUB |=> wb_data_o == a - b;
  endproperty
  property p_sbi; ok && opcode_i == OPC_SUBI |=> wb_data_o == a - m[6:0];
  endproperty
  property p_grd; guard_present_i && !guard_value_i[0] |=> !wb_en_o;
  endproperty
  property p_lat; ok && kn |=> wb_en_o; endproperty
  property p_unk; issue_valid_i && !kn |=> wb_unknown_op_o && !wb_en_o;
  endproperty
  a_neq: assert property (p_neq) else $error("neq result");
  a_nqi: assert property (p_nqi) else $error("neqi result");
  a_nz: assert property (p_nz) else $error("nzsel result");
  a_z: assert property (p_z) else $error("zsel result");
  a_sub: assert property (p_sub) else $error("sub result");
  a_sbi: assert property (p_sbi) else $error("subi result");
  a_grd: assert property (p_grd) else $error("guarded write");
  a_lat: assert property (p_lat) else $error("write missing");
  a_unk: assert property (p_unk) else $error("unknown op");
  c_grd: cover property (p_grd);
  c_sub: cover property (p_sub);
  c_nz: cover property (p_nz);
endmodule // gcsa_chk

// >>> dv/gcsa_rf.sv
// Register file model that absorbs the write-backs of the slice.
`timescale 1ns/100ps
module gcsa_rf
  import gcsa_pkg::*;
(
  input wire logic              clk_i, wb_en_o,
  input wire logic [REG_W-1:0]  wb_reg_o,
  input wire logic [DATA_W-1:0] wb_data_o
);
  logic [DATA_W-1:0] regs [128];
  // Only enabled write-backs land, so a false guard leaves a register alone.
  always_ff @(posedge clk_i) if (wb_en_o) regs[wb_reg_o] <= wb_data_o;
endmodule // gcsa_rf

// >>> dv/tb_top.sv
// Self-checking bench of the compare and subtract slice.
`timescale 1ns/100ps
module tb_top;
  import gcsa_pkg::*;
`define CHK(n, e, v) cmp_count++; if ((v) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", n, e, v); end
  logic clk_i = 0, rst_i = 1, issue_valid_i = 0, guard_present_i = 0;
  logic wb_en_o, wb_unknown_op_o;
  logic [SLOT_W-1:0] issue_slot_i = 1, wb_slot_o;
  logic [OPC_W-1:0]  opcode_i = 0;
  logic [MOD_W-1:0]  modifier_i = 0, dest_reg_i = 0, wb_reg_o;
  logic [DATA_W-1:0] first_source_i = 0, second_source_i = 0, guard_value_i = 0;
  logic [DATA_W-1:0] wb_data_o;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  gcsa_alu i_gcsa_alu (.*);
  gcsa_rf i_gcsa_rf (.*);
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc == 2000) begin n_errors++; finish_test(); end
  task automatic op(logic [7:0] o, logic [6:0] m, logic [31:0] a, b, gv,
                    logic gp, en, logic [31:0] e);
    @(posedge clk_i);
    issue_valid_i <= 1; opcode_i <= o; modifier_i <= m; dest_reg_i <= o[6:0];
    issue_slot_i <= 3'(1 + o % 5); first_source_i <= a; second_source_i <= b;
    guard_present_i <= gp; guard_value_i <= gv;
    @(posedge clk_i);
    issue_valid_i <= 0;
    #1 `CHK("enable", en, wb_en_o)
    if (en) begin `CHK("result", e, wb_data_o) end
    `CHK("dest", o[6:0], wb_reg_o)
    `CHK("slot", 3'(1 + o % 5), wb_slot_o)
    `CHK("unknown", !(o inside {OPC_NEQ, OPC_NEQI, OPC_NZSEL, OPC_ZSEL, OPC_SUB, OPC_SUBI}), wb_unknown_op_o)
  endtask
  task automatic t_ref();
    @(posedge clk_i);
    issue_valid_i <= 1; opcode_i <= OPC_SUB; issue_slot_i <= SLOT_NONE;
    guard_present_i <= 0;
    @(posedge clk_i);
    issue_valid_i <= 0;
    #1 `CHK("no slot", 1'b0, wb_en_o)
    op(8'h01, 0, 1, 1, 0, 0, 0, 0);
    $display("t_ref done");
  endtask
  task automatic t_cmp();
    op(OPC_NEQ, 0, 3, 4, 0, 0, 1, 1);
    op(OPC_NEQ, 0, 32'h8000_0000, 32'h8000_0000, 1, 1, 1, 0);
    op(OPC_NEQI, 7'h40, 32'hffff_ffc0, 0, 0, 0, 1, 0);
    op(OPC_NEQI, 7'h3f, 32'h0000_0100, 0, 0, 0, 1, 1);
    $display("t_cmp done");
  endtask
  task automatic t_sel();
    op(OPC_NZSEL, 0, 0, 32'hffff_ff9c, 0, 0, 1, 32'hffff_ff9c);
    op(OPC_NZSEL, 0, 32'h100, 5, 0, 0, 1, 0);
    op(OPC_ZSEL, 0, 0, 5, 0, 0, 1, 0);
    op(OPC_ZSEL, 0, 2, 1, 0, 0, 1, 1);
    $display("t_sel done");
  endtask
  task automatic t_sub();
    op(OPC_SUB, 0, 3, 4, 0, 0, 1, 32'hffff_ffff);
    op(OPC_SUB, 0, 32'h8000_0000, 4, 0, 0, 1, 32'h7fff_fffc);
    op(OPC_SUBI, 7'h7f, 32'hf11, 0, 0, 0, 1, 32'he92);
    op(OPC_SUBI, 7'h11, 1, 0, 0, 0, 1, 32'hffff_fff0);
    $display("t_sub done");
  endtask
  task automatic t_grd();
    op(OPC_SUB, 0, 9, 4, 1, 1, 1, 5);
    op(OPC_SUB, 0, 1, 1, 2, 1, 0, 0);
    @(posedge clk_i);
    #1 `CHK("kept", 32'h5, i_gcsa_rf.regs[13])
    $display("t_grd done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    t_cmp(); t_sel(); t_sub(); t_grd(); t_ref();
    finish_test();
  end
endmodule // tb_top
bind gcsa_alu gcsa_chk i_gcsa_chk (.*);
